// File: inc/board_mgmt_regs.svh
`ifndef BOARD_MGMT_REGS_SVH
`define BOARD_MGMT_REGS_SVH
// What this block does
// RQ1: byte-write opcode 0x9F clears reset cause, last error and power failure flags.
// RQ2: host sends data byte 0x69 with the clear command for it to act.
// RQ3: power cycle total counts up once per S5 to S0 transition.
// RQ4: word-read opcode 0x93 returns power cycles, low byte 0, high byte 1.
// RQ5: both counters start at zero after initial programming.
// RQ6: powered-on hours accumulate only while in S3 or S0.
// RQ7: word-read opcode 0x94 returns powered-on hours, low byte 0, high byte 1.
// RQ8: byte-write opcode 0xA0: bit 0 front status LED, bit 1 hot swap LED.
// RQ9: LED byte bit 2 is user output one, bit 3 user output two.
// RQ10: byte-read opcode 0xA0 returns LED state in the write layout.
// RQ11: upper four LED bits read zero and ignore writes.

// ----------------------------------------------------------------
// command opcodes and keys
// ----------------------------------------------------------------
`define OP_ERROR_CLEAR 8'h9F
`define OP_POWER_CYCLES 8'h93
`define OP_POWERED_HOURS 8'h94
`define OP_LED_STATE 8'hA0
`define ERROR_CLEAR_KEY 8'h69

// ----------------------------------------------------------------
// led byte layout
// ----------------------------------------------------------------
`define LED_FRONT_BIT 0
`define LED_HOTSWAP_BIT 1
`define LED_USER1_BIT 2
`define LED_USER2_BIT 3
`define LED_UNUSED_ZERO 4'h0
`define LED_RESET 1'b0

// ----------------------------------------------------------------
// power state encoding on power_state
// ----------------------------------------------------------------
`define PSTATE_S0 3'h0
`define PSTATE_S3 3'h3
`define PSTATE_S5 3'h5

// ----------------------------------------------------------------
// counters and timing
// ----------------------------------------------------------------
`define COUNT_RESET 16'h0000
`define COUNT_MAX 16'hFFFF
`define COUNT_ONE 16'h0001
`define READ_IDLE 16'h0000
`define HOUR_NS 64'd3600000000000
`define CLK_PERIOD_NS 64'd100
`endif

// File: inc/board_mgmt_pkg.sv
package board_mgmt_pkg;
    typedef logic [7:0] byte_type;
    typedef logic [15:0] word_type;
    typedef logic [2:0] pstate_type;
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_LED,
        SEL_CYCLES,
        SEL_HOURS
    } read_sel_type;
endpackage

// File: core/hours_timer.sv
`timescale 1ns/1ps
`include "board_mgmt_regs.svh"

module hours_timer #(
    parameter longint unsigned HOUR_CYCLES = `HOUR_NS / `CLK_PERIOD_NS,
    parameter int WIDTH = 36
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic run,
    output logic tick_q
);
    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;
    logic tick_d;

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    // counts only while running; holds the partial hour otherwise
    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (run) begin
            if (cnt_q == WIDTH'(HOUR_CYCLES - 1)) begin
                cnt_d = '0;
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + WIDTH'(1);
            end
        end
    end

    // prescaler registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    tick_needs_run_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        tick_q |-> $past(run)) // RQ6
        else $error("hour tick without running state");
    idle_holds_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !run |=> cnt_q == $past(cnt_q)) // RQ6
        else $error("prescaler moved while idle");
    hour_tick_c: cover property (@(posedge core_clk) disable iff (!rst_b) tick_q);
endmodule

// File: core/board_mgmt_command_set.sv
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "board_mgmt_regs.svh"

module board_mgmt_command_set #(
    parameter longint unsigned HOUR_CYCLES = `HOUR_NS / `CLK_PERIOD_NS,
    parameter int PRESCALE_WIDTH = 36
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [7:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic cmd_wr,
    input wire logic cmd_rd,
    output logic [15:0] cmd_rdata_q,
    input wire logic [2:0] power_state,
    output logic error_clear_q,
    output logic front_status_led_q,
    output logic hot_swap_led_q,
    output logic user_output_one_q,
    output logic user_output_two_q
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    board_mgmt_pkg::word_type power_cycle_total_q;
    board_mgmt_pkg::word_type power_cycle_total_d;
    board_mgmt_pkg::word_type powered_on_hours_q;
    board_mgmt_pkg::word_type powered_on_hours_d;
    board_mgmt_pkg::pstate_type prev_state_q;
    board_mgmt_pkg::pstate_type prev_state_d;
    board_mgmt_pkg::word_type cmd_rdata_d;
    board_mgmt_pkg::read_sel_type read_sel;
    logic error_clear_d;
    logic front_led_d;
    logic hotswap_led_d;
    logic user_one_d;
    logic user_two_d;
    logic cycle_event;
    logic hours_run;
    logic hour_tick;
    logic clear_hit;
    logic led_write;
    logic [3:0] led_state;

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    // clear acts only with the key byte; other data is ignored
    assign clear_hit = cmd_wr && (cmd_addr == `OP_ERROR_CLEAR)
        && (cmd_wdata == `ERROR_CLEAR_KEY); // RQ1 RQ2
    assign led_write = cmd_wr && (cmd_addr == `OP_LED_STATE); // RQ8
    assign led_state = {user_output_two_q, user_output_one_q,
        hot_swap_led_q, front_status_led_q};

    // read select by opcode
    always_comb begin
        if (!cmd_rd) begin
            read_sel = board_mgmt_pkg::SEL_NONE;
        end else if (cmd_addr == `OP_LED_STATE) begin
            read_sel = board_mgmt_pkg::SEL_LED;
        end else if (cmd_addr == `OP_POWER_CYCLES) begin
            read_sel = board_mgmt_pkg::SEL_CYCLES;
        end else if (cmd_addr == `OP_POWERED_HOURS) begin
            read_sel = board_mgmt_pkg::SEL_HOURS;
        end else begin
            read_sel = board_mgmt_pkg::SEL_NONE;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    // word reads put the low byte in [7:0], high byte in [15:8]
    always_comb begin
        case (read_sel)
            board_mgmt_pkg::SEL_LED: cmd_rdata_d = {8'h00, `LED_UNUSED_ZERO, led_state}; // RQ10 RQ11
            board_mgmt_pkg::SEL_CYCLES: cmd_rdata_d = power_cycle_total_q; // RQ4
            board_mgmt_pkg::SEL_HOURS: cmd_rdata_d = powered_on_hours_q; // RQ7
            default: cmd_rdata_d = `READ_IDLE;
        endcase
    end

    // read data stands one cycle only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_rdata_q <= `READ_IDLE;
        end else begin
            cmd_rdata_q <= cmd_rdata_d;
        end
    end

    // ----------------------------------------------------------------
    // error clear
    // ----------------------------------------------------------------
    // one pulse clears all three error registers at once
    assign error_clear_d = clear_hit; // RQ1

    // error clear register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            error_clear_q <= 1'b0;
        end else begin
            error_clear_q <= error_clear_d;
        end
    end

    // ----------------------------------------------------------------
    // led state
    // ----------------------------------------------------------------
    // only the low four bits are stored; upper bits dropped
    always_comb begin
        front_led_d = front_status_led_q;
        hotswap_led_d = hot_swap_led_q;
        user_one_d = user_output_one_q;
        user_two_d = user_output_two_q;
        if (led_write) begin
            front_led_d = cmd_wdata[`LED_FRONT_BIT]; // RQ8
            hotswap_led_d = cmd_wdata[`LED_HOTSWAP_BIT]; // RQ8
            user_one_d = cmd_wdata[`LED_USER1_BIT]; // RQ9
            user_two_d = cmd_wdata[`LED_USER2_BIT]; // RQ9
        end
    end

    // led registers drive the pins directly
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            front_status_led_q <= `LED_RESET;
            hot_swap_led_q <= `LED_RESET;
            user_output_one_q <= `LED_RESET;
            user_output_two_q <= `LED_RESET;
        end else begin
            front_status_led_q <= front_led_d;
            hot_swap_led_q <= hotswap_led_d;
            user_output_one_q <= user_one_d;
            user_output_two_q <= user_two_d;
        end
    end

    // ----------------------------------------------------------------
    // power cycle counter
    // ----------------------------------------------------------------
    // direct S5 to S0 step counts; saturates instead of wrapping
    assign cycle_event = (prev_state_q == `PSTATE_S5) && (power_state == `PSTATE_S0); // RQ3

    // next count and previous state
    always_comb begin
        prev_state_d = power_state;
        power_cycle_total_d = power_cycle_total_q;
        if (cycle_event && (power_cycle_total_q != `COUNT_MAX)) begin
            power_cycle_total_d = power_cycle_total_q + `COUNT_ONE; // RQ3
        end
    end

    // counter starts from zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_state_q <= `PSTATE_S5;
            power_cycle_total_q <= `COUNT_RESET; // RQ5
        end else begin
            prev_state_q <= prev_state_d;
            power_cycle_total_q <= power_cycle_total_d;
        end
    end

    // ----------------------------------------------------------------
    // operating hours counter
    // ----------------------------------------------------------------
    // time runs in S3 and S0 only
    assign hours_run = (power_state == `PSTATE_S0) || (power_state == `PSTATE_S3); // RQ6

    hours_timer #(
        .HOUR_CYCLES(HOUR_CYCLES),
        .WIDTH(PRESCALE_WIDTH)
    ) u_hours_timer (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .run(hours_run),
        .tick_q(hour_tick)
    );

    // next hour count, saturating
    always_comb begin
        powered_on_hours_d = powered_on_hours_q;
        if (hour_tick && (powered_on_hours_q != `COUNT_MAX)) begin
            powered_on_hours_d = powered_on_hours_q + `COUNT_ONE; // RQ6
        end
    end

    // hours register starts from zero
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            powered_on_hours_q <= `COUNT_RESET; // RQ5
        end else begin
            powered_on_hours_q <= powered_on_hours_d;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    err_clear_fire_a: assert property ( // RQ1
        cmd_wr && cmd_addr == `OP_ERROR_CLEAR && cmd_wdata == `ERROR_CLEAR_KEY
        |=> error_clear_q ##1 (error_clear_q == $past(clear_hit)))
        else $error("error clear pulse missing or too long");

    err_clear_cause_a: assert property ( // RQ1
        error_clear_q |-> $past(cmd_wr) && $past(cmd_addr) == `OP_ERROR_CLEAR
        && $past(cmd_wdata) == `ERROR_CLEAR_KEY)
        else $error("error clear without keyed command");

    cycle_count_a: assert property ( // RQ3
        prev_state_q == `PSTATE_S5 && power_state == `PSTATE_S0
        && power_cycle_total_q != `COUNT_MAX
        |=> power_cycle_total_q == $past(power_cycle_total_q) + `COUNT_ONE)
        else $error("power cycle not counted");

    cycle_hold_a: assert property ( // RQ3
        !(prev_state_q == `PSTATE_S5 && power_state == `PSTATE_S0)
        |=> $stable(power_cycle_total_q))
        else $error("power cycle count moved without transition");

    cycle_read_a: assert property ( // RQ4
        cmd_rd && cmd_addr == `OP_POWER_CYCLES
        |=> cmd_rdata_q == $past(power_cycle_total_q))
        else $error("power cycle read mismatch");

    count_start_a: assert property ( // RQ5
        $rose(rst_b) |-> power_cycle_total_q == `COUNT_RESET
        && powered_on_hours_q == `COUNT_RESET)
        else $error("counters not zero after reset");

    hours_gate_a: assert property ( // RQ6
        powered_on_hours_q != $past(powered_on_hours_q)
        |-> $past(power_state, 2) == `PSTATE_S0 || $past(power_state, 2) == `PSTATE_S3)
        else $error("hours counted outside S3 and S0");

    hours_read_a: assert property ( // RQ7
        cmd_rd && cmd_addr == `OP_POWERED_HOURS
        |=> cmd_rdata_q == $past(powered_on_hours_q))
        else $error("hours read mismatch");

    led_write_a: assert property ( // RQ8
        led_write |=> front_status_led_q == $past(cmd_wdata[`LED_FRONT_BIT])
        && hot_swap_led_q == $past(cmd_wdata[`LED_HOTSWAP_BIT]))
        else $error("led write not applied");

    user_write_a: assert property ( // RQ9
        led_write |=> user_output_one_q == $past(cmd_wdata[`LED_USER1_BIT])
        && user_output_two_q == $past(cmd_wdata[`LED_USER2_BIT]))
        else $error("user output write not applied");

    led_read_a: assert property ( // RQ10
        cmd_rd && cmd_addr == `OP_LED_STATE
        |=> cmd_rdata_q[3:0] == $past(led_state))
        else $error("led read mismatch");

    led_upper_a: assert property ( // RQ11
        $past(cmd_rd) && $past(cmd_addr) == `OP_LED_STATE
        |-> cmd_rdata_q[15:4] == 12'h000)
        else $error("led upper bits not zero");

    read_idle_a: assert property (
        !cmd_rd |=> cmd_rdata_q == `READ_IDLE)
        else $error("read data stands too long");

    clear_seen_c: cover property (error_clear_q);
    power_cycle_c: cover property (cycle_event ##1 cmd_rd && cmd_addr == `OP_POWER_CYCLES);
    hour_count_c: cover property (hour_tick ##1 cmd_rd && cmd_addr == `OP_POWERED_HOURS);
    led_roundtrip_c: cover property (led_write ##1 cmd_rd && cmd_addr == `OP_LED_STATE);
endmodule

// File: bench/board_mgmt_host.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// host side of the command port
// ----------------------------------------------------------------
module board_mgmt_host (
    input wire logic core_clk,
    input wire logic [15:0] cmd_rdata_q,
    output logic [7:0] cmd_addr,
    output logic [7:0] cmd_wdata,
    output logic cmd_wr,
    output logic cmd_rd
);
    // idle bus at time zero
    initial begin
        cmd_addr = 8'h00;
        cmd_wdata = 8'h00;
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
    end

    // one byte-write; released lines show the inverse of the last value
    task automatic write_cmd(input logic [7:0] op, input logic [7:0] data);
        @(posedge core_clk);
        cmd_addr <= op;
        cmd_wdata <= data;
        cmd_wr <= 1'b1;
        @(posedge core_clk);
        cmd_wr <= 1'b0;
        cmd_addr <= ~op;
        cmd_wdata <= ~data;
    endtask

    // one read; answer taken in the cycle after the strobe
    task automatic read_cmd(input logic [7:0] op, output logic [15:0] data);
        @(posedge core_clk);
        cmd_addr <= op;
        cmd_rd <= 1'b1;
        @(posedge core_clk);
        cmd_rd <= 1'b0;
        cmd_addr <= ~op;
        @(negedge core_clk);
        data = cmd_rdata_q;
    endtask
endmodule

// File: bench/test_board_mgmt_command_set.sv
`timescale 1ns/1ps
`include "board_mgmt_regs.svh"

module test_board_mgmt_command_set;
    logic core_clk;
    logic rst_b;
    logic [7:0] cmd_addr;
    logic [7:0] cmd_wdata;
    logic cmd_wr;
    logic cmd_rd;
    logic [15:0] cmd_rdata_q;
    logic [2:0] power_state;
    logic error_clear_q;
    logic front_status_led_q;
    logic hot_swap_led_q;
    logic user_output_one_q;
    logic user_output_two_q;
    logic [3:0] leds;
    logic [15:0] rd_val;
    int fail_count;
    int compares;
    logic [7:0] led_in [5];
    logic [3:0] led_exp [5];

    assign leds = {user_output_two_q, user_output_one_q, hot_swap_led_q, front_status_led_q};

    // ----------------------------------------------------------------
    // clock, host and design
    // ----------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    board_mgmt_host u_host (
        .core_clk(core_clk),
        .cmd_rdata_q(cmd_rdata_q),
        .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata),
        .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd)
    );

    board_mgmt_command_set #(.HOUR_CYCLES(10)) u_dut (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata),
        .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd),
        .cmd_rdata_q(cmd_rdata_q),
        .power_state(power_state),
        .error_clear_q(error_clear_q),
        .front_status_led_q(front_status_led_q),
        .hot_swap_led_q(hot_swap_led_q),
        .user_output_one_q(user_output_one_q),
        .user_output_two_q(user_output_two_q)
    );

    // ----------------------------------------------------------------
    // comparison and verdict
    // ----------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (fail_count == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // holds the power state for a number of sampling edges
    task automatic hold_state(input logic [2:0] st, input int n);
        @(posedge core_clk);
        power_state <= st;
        repeat (n) @(posedge core_clk);
    endtask

    // bound on the whole run
    initial begin
        #3000000;
        fail_count++;
        finish_test();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        fail_count = 0;
        compares = 0;
        rst_b = 1'b0;
        power_state = `PSTATE_S5;
        led_in = '{8'h05, 8'h0A, 8'hFF, 8'hF0, 8'h03};
        led_exp = '{4'h5, 4'hA, 4'hF, 4'h0, 4'h3};
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        check({15'h0000, error_clear_q}, 16'h0000);
        check({12'h000, leds}, 16'h0000);
        check(cmd_rdata_q, 16'h0000);
        u_host.read_cmd(`OP_POWER_CYCLES, rd_val);
        check(rd_val, 16'h0000);
        u_host.read_cmd(`OP_POWERED_HOURS, rd_val);
        check(rd_val, 16'h0000);
        // led rows: write, outputs, read back
        for (int i = 0; i < 5; i++) begin
            u_host.write_cmd(`OP_LED_STATE, led_in[i]);
            @(negedge core_clk);
            check({12'h000, leds}, {12'h000, led_exp[i]});
            u_host.read_cmd(`OP_LED_STATE, rd_val);
            check(rd_val, {12'h000, led_exp[i]});
        end
        // error clear: keyed pulse, wrong key ignored, read refused
        u_host.write_cmd(`OP_ERROR_CLEAR, `ERROR_CLEAR_KEY);
        @(negedge core_clk);
        check({15'h0000, error_clear_q}, 16'h0001);
        @(negedge core_clk);
        check({15'h0000, error_clear_q}, 16'h0000);
        u_host.write_cmd(`OP_ERROR_CLEAR, 8'h68);
        @(negedge core_clk);
        check({15'h0000, error_clear_q}, 16'h0000);
        u_host.read_cmd(`OP_ERROR_CLEAR, rd_val);
        check(rd_val, 16'h0000);
        check({12'h000, leds}, 16'h0003);
        // hours: 25 cycles in S3, 30 in S5, 5 in S0
        hold_state(`PSTATE_S3, 25);
        hold_state(`PSTATE_S5, 30);
        u_host.read_cmd(`OP_POWERED_HOURS, rd_val);
        check(rd_val, 16'h0002);
        hold_state(`PSTATE_S0, 5);
        hold_state(`PSTATE_S5, 5);
        u_host.read_cmd(`OP_POWERED_HOURS, rd_val);
        check(rd_val, 16'h0003);
        u_host.read_cmd(`OP_POWER_CYCLES, rd_val);
        check(rd_val, 16'h0001);
        // indirect S5 to S3 to S0 does not count, direct step does
        hold_state(`PSTATE_S3, 2);
        hold_state(`PSTATE_S0, 2);
        u_host.read_cmd(`OP_POWER_CYCLES, rd_val);
        check(rd_val, 16'h0001);
        hold_state(`PSTATE_S5, 2);
        hold_state(`PSTATE_S0, 2);
        u_host.read_cmd(`OP_POWER_CYCLES, rd_val);
        check(rd_val, 16'h0002);
        @(negedge core_clk);
        check(cmd_rdata_q, 16'h0000);
        // mid-run reset clears the led state and both counters
        @(posedge core_clk);
        rst_b <= 1'b0;
        power_state <= `PSTATE_S5;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(negedge core_clk);
        check({12'h000, leds}, 16'h0000);
        u_host.read_cmd(`OP_POWER_CYCLES, rd_val);
        check(rd_val, 16'h0000);
        u_host.read_cmd(`OP_POWERED_HOURS, rd_val);
        check(rd_val, 16'h0000);
        finish_test();
    end
endmodule
